// ---- design/ivl_top.sv ----
// Purpose: fixed-priority interrupt vectoring, enable and flag bits, low-power clock control
// Assumes: clk_sys never gated; vector memory answers combinationally in the fetch cycle
// Notes: sys_rst acts as power-up; rst_out asks the system for a reset
// How it works
// - vectors sit in top 32 bytes, lowest word at FFE0
// - vector word content loaded as new program counter
// - all reset causes take vector FFFE, priority 15
// - pin, oscillator and flash violation flags share vector FFFC, priority 14
// - individual enables gate the shared vector, global enable does not
// - fetch from register range or unused gap forces reset
// - timer channel 0 at FFEC prio 6; others and overflow FFEA prio 5
// - port one flags at FFE8 prio 4, port two at FFE2 prio 1
// - serial receive flag to FFF2, transmit flag to FFF0, any mode
// - separate serial receive and transmit enables, any serial mode
// - watchdog enable only works in interval mode, vector FFF4 prio 10
// - watchdog flag set by overflow or key error; cleared by power-up, pin reset
// - oscillator flag set on fault, pin flag set by pin event
// - own enables for oscillator, pin, flash violation, basic tick
// - basic tick flag takes lowest vector FFE0 prio 0
// - unassigned bits are not stored and read zero
// - interrupt wakes from any sleep level and returns to it
// - level one: cpu off, aux, sub, main and loop stay on
// - level two: as level one with loop regulation off
// - level three: cpu, main, sub, loop, osc output off; bias and aux on
// - level four: as three with bias off, aux on
// - deepest: also aux and crystal off, no clock
// - vectoring updates program counter and status (wake, gie clear)
`timescale 1ns/1ps
`default_nettype none
module ivl_top
	import ivl_pkg::*;
(
	input wire logic clk_sys, // block clock, 10 MHz
	input wire logic sys_rst, // async reset, acts as power-up
	input wire logic [ivl_pkg::ADDR_W-1:0] reg_addr, // register address
	input wire logic [ivl_pkg::DATA_W-1:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [ivl_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
	input wire ivl_pkg::ivl_cpu_in_t cpu_i, // requests from the core
	output ivl_pkg::ivl_cpu_out_t cpu_o, // program counter and status updates
	output logic [15:0] vec_mem_addr, // vector word address
	input wire logic [15:0] vec_mem_data, // vector word content
	input wire ivl_pkg::ivl_hw_evt_t hw_evt, // one-cycle events and modes
	input wire ivl_pkg::ivl_ext_req_t ext_req, // module-held flag levels
	output ivl_pkg::ivl_clk_ctl_t clk_ctl, // clock and oscillator enables
	output logic rst_out // reset request pulse
);
	import ivl_pkg::*;

	// ------------------------------------------------------------
	// constants and functions
	// ------------------------------------------------------------
	// implemented bit masks
	localparam logic [7:0] EN1_MASK = (8'h01 << BIT_WDOG) | (8'h01 << BIT_OSC)
		| (8'h01 << BIT_PIN_NM) | (8'h01 << BIT_FLASH_VIOL);
	localparam logic [7:0] EN2_MASK = (8'h01 << BIT_RX) | (8'h01 << BIT_TX) | (8'h01 << BIT_BTICK);
	localparam logic [7:0] NM_MASK = (8'h01 << BIT_OSC) | (8'h01 << BIT_PIN_NM) | (8'h01 << BIT_FLASH_VIOL);

	// word address of a vector
	function automatic logic [15:0] vec_addr(input logic [3:0] p);
		vec_addr = VEC_BASE + {11'h000, p, 1'b0};
	endfunction

	// highest pending priority
	function automatic logic [3:0] prio_enc(input logic [15:0] v);
		prio_enc = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (v[i]) begin
				prio_enc = i[3:0];
			end
		end
	endfunction

	// illegal fetch address
	function automatic logic fetch_bad(input logic [15:0] a);
		fetch_bad = (a <= FETCH_REG_TOP) || ((a >= GAP_LO) && (a <= GAP_HI));
	endfunction

	// hardware set wins over software write
	function automatic logic flag_next(input logic cur, input logic set, input logic wr, input logic wbit);
		if (set) begin
			flag_next = 1'b1;
		end else if (wr) begin
			flag_next = wbit;
		end else begin
			flag_next = cur;
		end
	endfunction

	// clock enables for a sleep level
	function automatic ivl_clk_ctl_t sleep_decode(input ivl_sleep_t s);
		sleep_decode = '1;
		case (s)
			SL_RUN: begin
				sleep_decode = '1;
			end
			SL_ONE: begin
				sleep_decode.cpu_run = 1'b0;
			end
			SL_TWO: begin
				sleep_decode.cpu_run = 1'b0;
				sleep_decode.fll_en = 1'b0;
			end
			SL_THREE: begin
				sleep_decode = '0;
				sleep_decode.aux_clk_en = 1'b1;
				sleep_decode.osc_bias_en = 1'b1;
				sleep_decode.xtal_en = 1'b1;
			end
			SL_FOUR: begin
				sleep_decode = '0;
				sleep_decode.aux_clk_en = 1'b1;
				sleep_decode.xtal_en = 1'b1;
			end
			SL_DEEP: begin
				sleep_decode = '0;
			end
			default: begin
				sleep_decode = '1;
			end
		endcase
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] en_one_r;
	logic [7:0] en_two_r;
	logic [7:0] flag_one_r;
	logic [7:0] flag_two_r;
	logic reset_pend_r;
	logic rst_out_r;
	ivl_vst_t vst_r;
	logic [3:0] prio_r;
	logic [15:0] vec_addr_r;
	logic [15:0] pc_value_r;
	ivl_sleep_t sleep_r;
	ivl_sleep_t saved_r;
	ivl_clk_ctl_t clk_ctl_r;
	logic [7:0] rdata_r;
	logic [15:0] pend;
	logic reset_cause;
	logic wr_en1;
	logic wr_en2;
	logic wr_fl1;
	logic wr_fl2;
	logic take_nm;

	assign wr_en1 = reg_wr && (reg_addr == OFS_EN_ONE);
	assign wr_en2 = reg_wr && (reg_addr == OFS_EN_TWO);
	assign wr_fl1 = reg_wr && (reg_addr == OFS_FLAG_ONE);
	assign wr_fl2 = reg_wr && (reg_addr == OFS_FLAG_TWO);
	assign take_nm = (vst_r == V_LOAD) && (prio_r == PRIO_NM);

	// ------------------------------------------------------------
	// reset causes
	// ------------------------------------------------------------
	// pin, watchdog expiry, key error and bad fetch
	always_comb begin
		reset_cause = hw_evt.pin_rst
			| (hw_evt.wdog_overflow & ~hw_evt.wdog_interval_mode)
			| hw_evt.flash_key_violation
			| (cpu_i.fetch_valid & fetch_bad(cpu_i.fetch_addr));
	end

	// reset request pulse and pending reset vector
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rst_out_r <= 1'b0;
			reset_pend_r <= 1'b1;
		end else begin
			rst_out_r <= reset_cause;
			if (reset_cause) begin
				reset_pend_r <= 1'b1;
			end else if ((vst_r == V_LOAD) && (prio_r == PRIO_RESET)) begin
				reset_pend_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// enable registers
	// ------------------------------------------------------------
	// software writes; shared-vector enables drop when that vector is taken
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			en_one_r <= EN_RST;
			en_two_r <= EN_RST;
		end else begin
			if (wr_en1) begin
				en_one_r <= reg_wdata & EN1_MASK;
			end else if (take_nm) begin
				en_one_r <= en_one_r & ~NM_MASK;
			end
			if (wr_en2) begin
				en_two_r <= reg_wdata & EN2_MASK;
			end
		end
	end

	// ------------------------------------------------------------
	// flag registers
	// ------------------------------------------------------------
	// watchdog flag: no software clear, pin reset clears it
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			flag_one_r <= FLAG_RST;
		end else begin
			if (hw_evt.wdog_overflow || hw_evt.flash_key_violation) begin
				flag_one_r[BIT_WDOG] <= 1'b1;
			end else if (hw_evt.pin_rst) begin
				flag_one_r[BIT_WDOG] <= 1'b0;
			end
			flag_one_r[BIT_OSC] <= flag_next(flag_one_r[BIT_OSC], hw_evt.osc_fault,
				wr_fl1, reg_wdata[BIT_OSC]);
			flag_one_r[BIT_PIN_NM] <= flag_next(flag_one_r[BIT_PIN_NM], hw_evt.pin_nm,
				wr_fl1, reg_wdata[BIT_PIN_NM]);
			flag_one_r[BIT_FLASH_VIOL] <= flag_next(flag_one_r[BIT_FLASH_VIOL], hw_evt.flash_viol,
				wr_fl1, reg_wdata[BIT_FLASH_VIOL]);
		end
	end

	// serial and basic tick flags
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			flag_two_r <= FLAG_RST;
		end else begin
			flag_two_r[BIT_RX] <= flag_next(flag_two_r[BIT_RX], hw_evt.serial_rx,
				wr_fl2, reg_wdata[BIT_RX]);
			flag_two_r[BIT_TX] <= flag_next(flag_two_r[BIT_TX], hw_evt.serial_tx,
				wr_fl2, reg_wdata[BIT_TX]);
			flag_two_r[BIT_BTICK] <= flag_next(flag_two_r[BIT_BTICK], hw_evt.base_tick,
				wr_fl2, reg_wdata[BIT_BTICK]);
		end
	end

	// ------------------------------------------------------------
	// pending requests
	// ------------------------------------------------------------
	// one bit per priority; maskable ones also need the global enable
	always_comb begin
		pend = 16'h0000;
		pend[PRIO_RESET] = reset_pend_r;
		pend[PRIO_NM] = |(flag_one_r & en_one_r & NM_MASK);
		pend[PRIO_DSP] = cpu_i.gie & ext_req.dsp_mailbox_out_flag;
		pend[PRIO_CONV] = cpu_i.gie & ext_req.converter_flag;
		pend[PRIO_WDOG] = cpu_i.gie & hw_evt.wdog_interval_mode
			& flag_one_r[BIT_WDOG] & en_one_r[BIT_WDOG];
		pend[PRIO_RX] = cpu_i.gie & flag_two_r[BIT_RX] & en_two_r[BIT_RX];
		pend[PRIO_TX] = cpu_i.gie & flag_two_r[BIT_TX] & en_two_r[BIT_TX];
		pend[PRIO_TCH0] = cpu_i.gie & ext_req.timer_ch0_flag;
		pend[PRIO_TGRP] = cpu_i.gie & ext_req.timer_group_flag;
		pend[PRIO_PORT1] = cpu_i.gie & (|ext_req.port_one_pin_flags);
		pend[PRIO_PORT2] = cpu_i.gie & (|ext_req.port_two_pin_flags);
		pend[PRIO_BTICK] = cpu_i.gie & flag_two_r[BIT_BTICK] & en_two_r[BIT_BTICK];
	end

	// ------------------------------------------------------------
	// vectoring sequence
	// ------------------------------------------------------------
	// pick, fetch the vector word, load it into the program counter
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			vst_r <= V_IDLE;
			prio_r <= 4'h0;
			vec_addr_r <= 16'h0000;
			pc_value_r <= 16'h0000;
		end else begin
			case (vst_r)
				V_IDLE: begin
					if (|pend) begin
						prio_r <= prio_enc(pend);
						vec_addr_r <= vec_addr(prio_enc(pend));
						vst_r <= V_FETCH;
					end
				end
				V_FETCH: begin
					pc_value_r <= vec_mem_data;
					vst_r <= V_LOAD;
				end
				V_LOAD: begin
					vst_r <= V_IDLE;
				end
				default: begin
					vst_r <= V_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// sleep level
	// ------------------------------------------------------------
	// vector entry wakes the core; return restores the saved level
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sleep_r <= SL_RUN;
			saved_r <= SL_RUN;
		end else begin
			if (vst_r == V_LOAD) begin
				sleep_r <= SL_RUN;
				if (prio_r == PRIO_RESET) begin
					saved_r <= SL_RUN;
				end else begin
					saved_r <= sleep_r;
				end
			end else if (cpu_i.reti) begin
				sleep_r <= saved_r;
				saved_r <= SL_RUN;
			end else if (cpu_i.sleep_req) begin
				sleep_r <= cpu_i.sleep_level;
			end
		end
	end

	// clock enables follow the sleep level one cycle later
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			clk_ctl_r <= '1;
		end else begin
			clk_ctl_r <= sleep_decode(sleep_r);
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	// data only in the cycle after the strobe, zero elsewhere
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					OFS_EN_ONE: begin
						rdata_r <= en_one_r & EN1_MASK;
					end
					OFS_EN_TWO: begin
						rdata_r <= en_two_r & EN2_MASK;
					end
					OFS_FLAG_ONE: begin
						rdata_r <= flag_one_r & EN1_MASK;
					end
					OFS_FLAG_TWO: begin
						rdata_r <= flag_two_r & EN2_MASK;
					end
					OFS_STATUS: begin
						rdata_r[ST_SLEEP_LSB +: 3] <= sleep_r;
						rdata_r[ST_BUSY] <= (vst_r != V_IDLE);
						rdata_r[ST_PRIO_LSB +: 4] <= prio_r;
					end
					default: begin
						rdata_r <= 8'h00;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// core updates: load strobe and gie clear in the load cycle
	always_comb begin
		cpu_o.pc_load = (vst_r == V_LOAD);
		cpu_o.pc_value = pc_value_r;
		cpu_o.gie_clear = (vst_r == V_LOAD);
	end

	assign vec_mem_addr = vec_addr_r;
	assign reg_rdata = rdata_r;
	assign clk_ctl = clk_ctl_r;
	assign rst_out = rst_out_r;
endmodule
`default_nettype wire

// ---- design/ivl_pkg.sv ----
// Purpose: shared constants and types for the interrupt vector and low-power control block
// Assumes: byte-wide register port, 16-bit CPU address space
// Notes: vector word address is the base plus twice the priority
package ivl_pkg;
	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [2:0] OFS_EN_ONE = 3'h0;
	localparam logic [2:0] OFS_EN_TWO = 3'h1;
	localparam logic [2:0] OFS_FLAG_ONE = 3'h2;
	localparam logic [2:0] OFS_FLAG_TWO = 3'h3;
	localparam logic [2:0] OFS_STATUS = 3'h4;
	localparam logic [7:0] EN_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h00;
	// ------------------------------------------------------------
	// field positions (register one / register two)
	// ------------------------------------------------------------
	localparam int BIT_WDOG = 0;
	localparam int BIT_OSC = 1;
	localparam int BIT_PIN_NM = 4;
	localparam int BIT_FLASH_VIOL = 5;
	localparam int BIT_RX = 0;
	localparam int BIT_TX = 1;
	localparam int BIT_BTICK = 7;
	localparam int ST_SLEEP_LSB = 0;
	localparam int ST_BUSY = 3;
	localparam int ST_PRIO_LSB = 4;
	// ------------------------------------------------------------
	// vectors and priorities
	// ------------------------------------------------------------
	localparam logic [15:0] VEC_BASE = 16'hFFE0;
	localparam logic [3:0] PRIO_RESET = 4'hF;
	localparam logic [3:0] PRIO_NM = 4'hE;
	localparam logic [3:0] PRIO_DSP = 4'hD;
	localparam logic [3:0] PRIO_CONV = 4'hC;
	localparam logic [3:0] PRIO_WDOG = 4'hA;
	localparam logic [3:0] PRIO_RX = 4'h9;
	localparam logic [3:0] PRIO_TX = 4'h8;
	localparam logic [3:0] PRIO_TCH0 = 4'h6;
	localparam logic [3:0] PRIO_TGRP = 4'h5;
	localparam logic [3:0] PRIO_PORT1 = 4'h4;
	localparam logic [3:0] PRIO_PORT2 = 4'h1;
	localparam logic [3:0] PRIO_BTICK = 4'h0;
	// ------------------------------------------------------------
	// illegal fetch ranges
	// ------------------------------------------------------------
	localparam logic [15:0] FETCH_REG_TOP = 16'h01FF;
	localparam logic [15:0] GAP_LO = 16'h0600;
	localparam logic [15:0] GAP_HI = 16'h0BFF;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SL_RUN = 3'b000, SL_ONE = 3'b001, SL_TWO = 3'b011,
		SL_THREE = 3'b010, SL_FOUR = 3'b110, SL_DEEP = 3'b111
	} ivl_sleep_t;
	typedef enum logic [1:0] {V_IDLE = 2'b00, V_FETCH = 2'b01, V_LOAD = 2'b11} ivl_vst_t;
	typedef struct packed {
		logic gie;
		logic sleep_req;
		ivl_sleep_t sleep_level;
		logic reti;
		logic fetch_valid;
		logic [15:0] fetch_addr;
	} ivl_cpu_in_t;
	typedef struct packed {
		logic pc_load;
		logic [15:0] pc_value;
		logic gie_clear;
	} ivl_cpu_out_t;
	typedef struct packed {
		logic cpu_run;
		logic main_clk_en;
		logic sub_clk_en;
		logic aux_clk_en;
		logic fll_en;
		logic osc_out_en;
		logic osc_bias_en;
		logic xtal_en;
	} ivl_clk_ctl_t;
	typedef struct packed {
		logic wdog_interval_mode;
		logic wdog_overflow;
		logic flash_key_violation;
		logic pin_rst;
		logic pin_nm;
		logic osc_fault;
		logic flash_viol;
		logic serial_rx;
		logic serial_tx;
		logic base_tick;
	} ivl_hw_evt_t;
	typedef struct packed {
		logic dsp_mailbox_out_flag;
		logic converter_flag;
		logic timer_ch0_flag;
		logic timer_group_flag;
		logic [7:0] port_one_pin_flags;
		logic [7:0] port_two_pin_flags;
	} ivl_ext_req_t;
endpackage

// ---- dv/ivl_core_model.sv ----
// Purpose: core-side partner holding the vector words and the global enable bit
// Assumes: vector memory answers in the same cycle as its address
// Notes: each vector word holds the inverse of its own address
`timescale 1ns/1ps
`default_nettype none
module ivl_core_model
	import ivl_pkg::*;
(
	input wire logic clk_sys, // block clock
	input wire logic sys_rst, // async reset
	input wire logic gie_set, // bench asks the core to enable interrupts
	input wire ivl_pkg::ivl_cpu_out_t cpu_o, // vectoring updates
	input wire logic [15:0] vec_mem_addr, // vector word address
	output logic [15:0] vec_mem_data, // vector word content
	output var logic gie // global enable as held in the status register
);
	// distinct handler per word, so a wrong word cannot pass
	assign vec_mem_data = ~vec_mem_addr;
	// status bit: cleared on handler entry, set only on request
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			gie <= 1'b0;
		end else if (cpu_o.gie_clear) begin
			gie <= 1'b0;
		end else if (gie_set) begin
			gie <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- dv/ivl_top_props.sv ----
// Purpose: port-level assertions for vectoring, sleep gating and reset requests
// Assumes: one clock domain, sys_rst async active high
// Notes: bound to ivl_top after the module
`timescale 1ns/1ps
`default_nettype none
module ivl_top_props
	import ivl_pkg::*;
(
	input wire logic clk_sys, // block clock
	input wire logic sys_rst, // async reset
	input wire logic [ivl_pkg::ADDR_W-1:0] reg_addr, // register address
	input wire logic [ivl_pkg::DATA_W-1:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [ivl_pkg::DATA_W-1:0] reg_rdata, // read data
	input wire ivl_pkg::ivl_cpu_in_t cpu_i, // core requests
	input wire ivl_pkg::ivl_cpu_out_t cpu_o, // core updates
	input wire logic [15:0] vec_mem_addr, // vector address
	input wire logic [15:0] vec_mem_data, // vector content
	input wire ivl_pkg::ivl_hw_evt_t hw_evt, // events
	input wire ivl_pkg::ivl_ext_req_t ext_req, // module flags
	input wire ivl_pkg::ivl_clk_ctl_t clk_ctl, // clock enables
	input wire logic rst_out // reset request
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// ----
	// expected clock enables and read-zero bits
	// ----
	function automatic logic [7:0] clk_of(ivl_sleep_t l);
		case (l)
			SL_ONE: clk_of = 8'h7F;
			SL_TWO: clk_of = 8'h77;
			SL_THREE: clk_of = 8'h13;
			SL_FOUR: clk_of = 8'h11;
			SL_DEEP: clk_of = 8'h00;
			default: clk_of = 8'hFF;
		endcase
	endfunction
	function automatic logic [7:0] zero_of(logic [2:0] a);
		case (a)
			3'h0, 3'h2: zero_of = 8'hCC;
			3'h1, 3'h3: zero_of = 8'h7C;
			3'h4: zero_of = 8'h00;
			default: zero_of = 8'hFF;
		endcase
	endfunction
	// sleep request settles into the clock enables two edges on
	property p_sleep;
		(cpu_i.sleep_req && !cpu_i.reti && !cpu_o.pc_load) ##1
		(!cpu_i.reti && !cpu_i.sleep_req && !cpu_o.pc_load)
		|=> clk_ctl == clk_of($past(cpu_i.sleep_level, 2));
	endproperty
	a_vec_top_word: assert property (cpu_o.pc_load |->
		$past(vec_mem_addr) >= 16'hFFE0 && ($past(vec_mem_addr) & 16'h0001) == 16'h0000)
		else $error("vector word outside the top block");
	a_pc_from_word: assert property (cpu_o.pc_load |-> cpu_o.pc_value == $past(vec_mem_data))
		else $error("program counter not the vector content");
	a_status_with_pc: assert property (cpu_o.gie_clear == cpu_o.pc_load
		&& !(cpu_o.pc_load && $past(cpu_o.pc_load)))
		else $error("status update apart from counter load");
	a_reset_cause_vec: assert property (
		hw_evt.pin_rst || hw_evt.flash_key_violation || (hw_evt.wdog_overflow && !hw_evt.wdog_interval_mode)
		|=> rst_out ##[0:6] (cpu_o.pc_load && $past(vec_mem_addr) == 16'hFFFE))
		else $error("reset cause without reset word");
	a_bad_fetch_rst: assert property (cpu_i.fetch_valid && (cpu_i.fetch_addr <= 16'h01FF ||
		(cpu_i.fetch_addr >= 16'h0600 && cpu_i.fetch_addr <= 16'h0BFF)) |=> rst_out)
		else $error("illegal fetch without reset");
	a_sleep_gates: assert property (p_sleep)
		else $error("clock enables wrong for sleep level");
	a_wake_to_run: assert property (cpu_o.pc_load |-> ##[1:2] clk_ctl == 8'hFF)
		else $error("vector entry did not wake");
	a_unused_bits_zero: assert property (reg_rd |=> (reg_rdata & zero_of($past(reg_addr))) == 8'h00)
		else $error("unused bit reads nonzero");
	c_shared_word: cover property (cpu_o.pc_load && cpu_o.pc_value == 16'h0003);
	c_deep_sleep: cover property (clk_ctl == 8'h00);
	c_reset_req: cover property (rst_out);
endmodule
bind ivl_top ivl_top_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_i(cpu_i),
	.cpu_o(cpu_o), .vec_mem_addr(vec_mem_addr), .vec_mem_data(vec_mem_data), .hw_evt(hw_evt),
	.ext_req(ext_req), .clk_ctl(clk_ctl), .rst_out(rst_out));
`default_nettype wire

// ---- dv/ivl_top_tb.sv ----
// Purpose: self-checking bench for vector choice, enables, flags, sleep and reset requests
// Assumes: core model returns the inverse of the vector address
// Notes: random data from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module ivl_top_tb;
	import ivl_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, r;
	logic reg_wr = 1'b0, reg_rd = 1'b0, gie, gie_set = 1'b0, sleep_req = 1'b0, reti = 1'b0;
	logic fetch_valid = 1'b0, rst_out;
	ivl_sleep_t sleep_level = SL_RUN;
	logic [15:0] fetch_addr = 16'h0000, vec_mem_addr, vec_mem_data;
	ivl_cpu_in_t cpu_i;
	ivl_cpu_out_t cpu_o;
	ivl_hw_evt_t hw_evt = '0; // bits: 8 ovf 7 key 6 pin rst 5 pin 4 osc 3 flash 2 rx 1 tx 0 tick
	ivl_ext_req_t ext_req = '0;
	ivl_clk_ctl_t clk_ctl;
	int fails = 0, checks = 0;
	int nm_bit[3] = '{1, 4, 5}, nm_evt[3] = '{4, 5, 3}, src_evt[4] = '{2, 1, 0, 8};
	logic [3:0] pr[10] = '{4'hD, 4'hC, 4'h6, 4'h5, 4'h4, 4'h1, 4'h9, 4'h8, 4'h0, 4'hA};
	ivl_sleep_t lv[5] = '{SL_ONE, SL_TWO, SL_THREE, SL_FOUR, SL_DEEP};
	logic [7:0] ck[5] = '{8'h7F, 8'h77, 8'h13, 8'h11, 8'h00};
	logic [15:0] fa[7] = '{16'h0000, 16'h01FF, 16'h0600, 16'h0BFF, 16'h0200, 16'h05FF, 16'h0C00};
	assign cpu_i = {gie, sleep_req, sleep_level, reti, fetch_valid, fetch_addr};
	always #50 clk_sys = ~clk_sys;
	ivl_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_i(cpu_i), .cpu_o(cpu_o),
		.vec_mem_addr(vec_mem_addr), .vec_mem_data(vec_mem_data), .hw_evt(hw_evt), .ext_req(ext_req),
		.clk_ctl(clk_ctl), .rst_out(rst_out));
	ivl_core_model u_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .gie_set(gie_set), .cpu_o(cpu_o),
		.vec_mem_addr(vec_mem_addr), .vec_mem_data(vec_mem_data), .gie(gie));
	// ----
	// shared tasks
	// ----
	task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [2:0] a, logic [7:0] exp, string what);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk({8'h00, reg_rdata}, {8'h00, exp}, what);
	endtask
	task automatic evt(int b);
		@(posedge clk_sys);
		hw_evt[b] <= 1'b1;
		@(posedge clk_sys);
		hw_evt[b] <= 1'b0;
	endtask
	// pulse global enable (e) or a sleep request (s) or a handler return
	task automatic core(int e, logic s, ivl_sleep_t l);
		@(posedge clk_sys);
		gie_set <= 1'(e);
		sleep_req <= e == 0 && s;
		reti <= e == 0 && !s;
		sleep_level <= l;
		@(posedge clk_sys);
		{gie_set, sleep_req, reti} <= 3'b000;
	endtask
	task automatic vec(logic [3:0] p, string what);
		int n = 0;
		@(negedge clk_sys);
		while (cpu_o.pc_load !== 1'b1 && n < 16) begin
			@(negedge clk_sys);
			n++;
		end
		chk({15'h0, cpu_o.pc_load}, 16'h0001, what);
		chk(cpu_o.pc_value, ~(16'hFFE0 + {11'h0, p, 1'b0}), what);
	endtask
	task automatic novec(string what);
		repeat (8) begin
			@(negedge clk_sys);
			chk({15'h0, cpu_o.pc_load}, 16'h0000, what);
		end
	endtask
	// raise or drop one maskable source
	task automatic src(int k, logic on);
		@(posedge clk_sys);
		case (k)
			0: ext_req.dsp_mailbox_out_flag <= on;
			1: ext_req.converter_flag <= on;
			2: ext_req.timer_ch0_flag <= on;
			3: ext_req.timer_group_flag <= on;
			4: ext_req.port_one_pin_flags <= on ? 8'($urandom) | 8'h01 : 8'h00;
			5: ext_req.port_two_pin_flags <= on ? 8'($urandom) | 8'h80 : 8'h00;
			default: ;
		endcase
		if (k > 5 && on) begin
			if (k == 9) wr(OFS_EN_ONE, 8'h01);
			evt(src_evt[k-6]);
		end else if (k > 5) begin
			wr(k == 9 ? OFS_EN_ONE : OFS_FLAG_TWO, 8'h00);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hung run guard, tests take under 3000 cycles
	initial begin
		#(20000 * 100);
		fails++;
		wrap_up();
	end
	// ----
	// test sequence
	// ----
	initial begin
		r = 8'($urandom(18));
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		vec(4'hF, "power-up word");
		for (int a = 0; a < 4; a++) rd(3'(a), 8'h00, "reset value");
		repeat (6) begin
			r = 8'($urandom);
			wr(OFS_EN_TWO, r);
			rd(OFS_EN_TWO, r & 8'h83, "enable two");
			wr(OFS_FLAG_ONE, r);
			rd(OFS_FLAG_ONE, r & 8'h32, "flag one");
			wr(OFS_FLAG_TWO, r);
			rd(OFS_FLAG_TWO, r & 8'h83, "flag two");
			wr(OFS_FLAG_ONE, 8'h00);
			wr(OFS_FLAG_TWO, 8'h00);
			wr(OFS_EN_ONE, r);
			rd(OFS_EN_ONE, r & 8'h33, "enable one");
			wr(OFS_EN_ONE, 8'h00);
			wr(3'(5 + r[1:0] % 3), r);
			rd(3'(5 + r[1:0] % 3), 8'h00, "unmapped");
		end
		$display("test registers done");
		foreach (nm_bit[i]) begin
			evt(nm_evt[i]);
			novec("source disabled");
			rd(OFS_FLAG_ONE, 8'(1 << nm_bit[i]), "source flag");
			wr(OFS_EN_ONE, 8'(1 << nm_bit[i]));
			vec(4'hE, "shared word");
			wr(OFS_FLAG_ONE, 8'h00);
		end
		$display("test shared word done");
		wr(OFS_EN_TWO, 8'h83);
		hw_evt.wdog_interval_mode <= 1'b1;
		for (int k = 0; k < 10; k++) begin
			src(k, 1'b1);
			core(1, 1'b0, SL_RUN);
			vec(pr[k], "maskable word");
			src(k, 1'b0);
		end
		$display("test maskable words done");
		src(5, 1'b1);
		src(2, 1'b1);
		novec("global enable low");
		core(1, 1'b0, SL_RUN);
		vec(4'h6, "higher first");
		src(2, 1'b0);
		core(1, 1'b0, SL_RUN);
		vec(4'h1, "lower kept");
		src(5, 1'b0);
		$display("test priority done");
		foreach (lv[i]) begin
			core(0, 1'b1, lv[i]);
			repeat (2) @(negedge clk_sys);
			chk({8'h00, clk_ctl}, {8'h00, ck[i]}, "sleep clocks");
			src(4, 1'b1);
			core(1, 1'b0, SL_RUN);
			vec(4'h4, "wake word");
			repeat (2) @(negedge clk_sys);
			chk({8'h00, clk_ctl}, 16'h00FF, "handler runs");
			src(4, 1'b0);
			core(0, 1'b0, SL_RUN);
			repeat (2) @(negedge clk_sys);
			chk({8'h00, clk_ctl}, {8'h00, ck[i]}, "back asleep");
			rd(OFS_STATUS, {PRIO_PORT1, 1'b0, 3'(lv[i])}, "status");
		end
		$display("test sleep done");
		foreach (fa[i]) begin
			@(posedge clk_sys);
			fetch_addr <= fa[i];
			fetch_valid <= 1'b1;
			@(posedge clk_sys);
			fetch_valid <= 1'b0;
			@(negedge clk_sys);
			chk({15'h0, rst_out}, {15'h0, i < 4}, "fetch reset");
		end
		@(posedge clk_sys);
		hw_evt.wdog_interval_mode <= 1'b0;
		evt(8);
		vec(4'hF, "watchdog reset");
		evt(7);
		vec(4'hF, "key reset");
		rd(OFS_FLAG_ONE, 8'h01, "flag kept");
		evt(6);
		vec(4'hF, "pin reset");
		rd(OFS_FLAG_ONE, 8'h00, "flag cleared");
		// flag set again, then a mid-run power-up must clear it
		evt(8);
		vec(4'hF, "overflow again");
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		vec(4'hF, "power-up again");
		rd(OFS_FLAG_ONE, 8'h00, "power-up clears");
		$display("test resets done");
		wrap_up();
	end
endmodule
`default_nettype wire
